// *** rsq_cfg.svh ***
// Constants of the reset sequencer and clock control block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// ***********************************************
// Register indices (byte address = 4 * index)
// ***********************************************
`define RSQ_IDX_TRIM_CTL  6'h35
`define RSQ_IDX_CLK_CTL   6'h3a
`define RSQ_IDX_TRIM_HI   6'h3b
`define RSQ_IDX_FLAGS     6'h3c

// ***********************************************
// Field positions and reset values
// ***********************************************
`define RSQ_LAT_BIT       1
`define RSQ_PGM_BIT       0
`define RSQ_CLKOUT_BIT    1
`define RSQ_SLOW_BIT      0
`define RSQ_WDF_BIT       4
`define RSQ_LSF_BIT       2
`define RSQ_TRIM_HI_RST   8'hff
`define RSQ_VEC_LO        16'hfffe
`define RSQ_VEC_HI        16'hffff

// ***********************************************
// Timing
// ***********************************************
`define RSQ_CLK_PERIOD_NS 40
`define RSQ_DELAY_SHORT   256
`define RSQ_DELAY_LONG    4096
`define RSQ_FETCH_CYCLES  2
`define RSQ_SLOW_DIV      32
`define RSQ_WD_PULSE_NS   2000
`define RSQ_WD_PULSE_CYC  ((`RSQ_WD_PULSE_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_PROG_TIME_NS  5000000
`define RSQ_PROG_CYC      ((`RSQ_PROG_TIME_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

`endif

// *** rsq_pkg.sv ***
// Types shared by the reset sequencer modules.
// Assumes nothing beyond the compile order.
package rsq_pkg;

  // ***********************************************
  // Sequencer phases
  // ***********************************************
  typedef enum logic [1:0] {
    RSQ_ACTIVE,
    RSQ_DELAY,
    RSQ_FETCH,
    RSQ_RUN
  } rsq_state_t;

endpackage : rsq_pkg

// *** rsq_link_if.sv ***
// Carrier between the sequencer core, its synchroniser and its divider.
// Assumes all three run on the same system clock.
`timescale 1ns/1ps
interface rsq_link_if;
  logic async_req;
  logic pin_raw;
  logic supply_low_raw;
  logic req_sync;
  logic pin_sync;
  logic supply_low_sync;
  logic slow_sel;
  logic clk_out_en;
  logic cpu_tick;
  logic clk_out;

  modport sync_mp (input async_req, pin_raw, supply_low_raw, output req_sync, pin_sync, supply_low_sync);
  modport div_mp  (input slow_sel, clk_out_en, output cpu_tick, clk_out);
  modport core_mp (output async_req, pin_raw, supply_low_raw, slow_sel, clk_out_en,
                   input req_sync, pin_sync, supply_low_sync, cpu_tick, clk_out);
endinterface : rsq_link_if

// *** rsq_sync.sv ***
// Reset request synchroniser and two-flop input synchronisers.
// Assumes async_req is glitch-free enough to act as an asynchronous set.
`timescale 1ns/1ps
module rsq_sync (
  // Clock and reset
  input  wire logic    sys_clk_in,
  input  wire logic    reset_in,
  // Link to core
  rsq_link_if.sync_mp  lk
);
  import rsq_pkg::*;

  logic req_meta_r;
  logic req_q_r;
  logic pin_meta_r;
  logic pin_q_r;
  logic sup_meta_r;
  logic sup_q_r;
  wire  req_rst = reset_in | lk.async_req;

  // Set at once, released only through two clock edges
  always_ff @(posedge sys_clk_in or posedge req_rst)
  begin
    if (req_rst)
    begin
      req_meta_r <= 1'b1;
      req_q_r    <= 1'b1;
    end
    else
    begin
      req_meta_r <= 1'b0;
      req_q_r    <= req_meta_r;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_meta_r <= 1'b1;
      pin_q_r    <= 1'b1;
      sup_meta_r <= 1'b1;
      sup_q_r    <= 1'b1;
    end
    else
    begin
      pin_meta_r <= lk.pin_raw;
      pin_q_r    <= pin_meta_r;
      sup_meta_r <= lk.supply_low_raw;
      sup_q_r    <= sup_meta_r;
    end
  end

  assign lk.req_sync        = req_q_r;
  assign lk.pin_sync        = pin_q_r;
  assign lk.supply_low_sync = sup_q_r;
endmodule : rsq_sync

// *** rsq_clk_div.sv ***
// Slow-mode CPU clock enable and clock output generator.
// Assumes slow_sel and clk_out_en come from registers on the same clock.
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_clk_div #(
  parameter int unsigned DIV = `RSQ_SLOW_DIV
) (
  // Clock and reset
  input  wire logic   sys_clk_in,
  input  wire logic   reset_in,
  // Link to core
  rsq_link_if.div_mp  lk
);
  import rsq_pkg::*;

  localparam int DW = $clog2(DIV);

  if (DIV < 2 || (1 << DW) != DIV)
  begin : g_chk
    $error("DIV must be a power of two of at least two");
  end

  logic [DW-1:0] cnt_r;
  logic          tick_r;
  logic          out_r;
  wire           last = (cnt_r == DW'(DIV - 1));

  // Output toggles per CPU tick, so it shows f_cpu/2; a flop cannot show f_osc itself
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
      out_r  <= 1'b0;
    end
    else
    begin
      cnt_r  <= DW'(cnt_r + 1'b1);
      tick_r <= lk.slow_sel ? last : 1'b1;
      out_r  <= lk.clk_out_en ? (out_r ^ tick_r) : 1'b0;
    end
  end

  assign lk.cpu_tick = tick_r;
  assign lk.clk_out  = out_r;
endmodule : rsq_clk_div

// *** rsq_reset_seq.sv ***
// Reset sequencer with clock and trim control registers behind classic Wishbone.
// Assumes a same-clock watchdog and illegal-opcode pulse, and an open-drain reset pin.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module rsq_reset_seq #(
  parameter int unsigned DELAY_SHORT = `RSQ_DELAY_SHORT,
  parameter int unsigned DELAY_LONG  = `RSQ_DELAY_LONG,
  parameter int unsigned WD_PULSE    = `RSQ_WD_PULSE_CYC,
  parameter int unsigned PROG_CYCLES = `RSQ_PROG_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Reset pin, open drain
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_n_out,
  // Reset sources and options
  input  wire logic        supply_low_in,
  input  wire logic        supply_det_en_in,
  input  wire logic        wd_underflow_in,
  input  wire logic        illegal_op_in,
  input  wire logic        slow_clk_src_in,
  // CPU side
  output logic             cpu_reset_out,
  output logic             vec_fetch_out,
  output logic      [15:0] vec_addr_out,
  output logic             cpu_clk_en_out,
  // Clock output and trim
  output logic             clk_out_out,
  output logic             clk_out_en_out,
  output logic      [7:0]  trim_high_out,
  output logic             trim_latch_out,
  output logic             trim_prog_out
);
  import rsq_pkg::*;

  localparam int CW = $clog2(DELAY_LONG + 1);
  localparam int WW = $clog2(WD_PULSE + 1);
  localparam int PW = $clog2(PROG_CYCLES + 1);
  localparam int FW = 2;

  // The pin pulse check below counts eight cycles, so shorter watchdog pulses are refused
  if (DELAY_SHORT < 1 || DELAY_SHORT > DELAY_LONG || WD_PULSE < 8 || PROG_CYCLES < 1)
  begin : g_chk
    $error("Counts must be nonzero, the watchdog pulse at least eight, the short delay not above the long");
  end

  // ***********************************************
  // Submodules
  // ***********************************************
  rsq_link_if lk ();

  rsq_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .lk         (lk)
  );

  rsq_clk_div u_div (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .lk         (lk)
  );

  // ***********************************************
  // State
  // ***********************************************
  rsq_state_t    state_r;
  rsq_state_t    state_nxt;
  logic [CW-1:0] dly_cnt_r;
  logic [CW-1:0] dly_cnt_nxt;
  logic [FW-1:0] fch_cnt_r;
  logic [FW-1:0] fch_cnt_nxt;
  logic [WW-1:0] wdp_cnt_r;
  logic [WW-1:0] wdp_cnt_nxt;
  logic [PW-1:0] prog_cnt_r;
  logic          int_cause_r;
  logic          int_cause_nxt;
  logic          mask_r;
  logic          oe_n_r;
  logic          cpu_reset_r;
  logic          vec_fetch_r;
  logic [15:0]   vec_addr_r;
  logic          lat_r;
  logic          pgm_r;
  logic          clkout_en_r;
  logic          slow_r;
  logic [7:0]    trim_hi_r;
  logic          wdf_r;
  logic          lsf_r;
  logic          ack_r;
  logic [7:0]    rd_byte_r;

  // The pin reads low while we drive it; the mask keeps that from retriggering us
  assign lk.async_req      = ~rst_pin_in & ~mask_r;
  assign lk.pin_raw        = rst_pin_in;
  assign lk.supply_low_raw = supply_low_in;
  assign lk.slow_sel       = slow_r;
  assign lk.clk_out_en     = clkout_en_r;

  // ***********************************************
  // Source decode
  // ***********************************************
  wire           lvd_on    = lk.supply_low_sync & supply_det_en_in;
  wire           int_src   = lvd_on | wd_underflow_in | illegal_op_in;
  wire           src_any   = lk.req_sync | int_src;
  wire [CW-1:0]  dly_lim   = slow_clk_src_in ? CW'(DELAY_SHORT) : CW'(DELAY_LONG);
  wire           dly_last  = (dly_cnt_r == CW'(dly_lim - 1'b1));
  wire           fch_last  = (fch_cnt_r == FW'(`RSQ_FETCH_CYCLES - 1));

  // ***********************************************
  // Sequencer
  // ***********************************************
  always_comb
  begin
    state_nxt   = state_r;
    dly_cnt_nxt = dly_cnt_r;
    fch_cnt_nxt = fch_cnt_r;
    if (src_any)
    begin
      state_nxt   = RSQ_ACTIVE;
      dly_cnt_nxt = '0;
    end
    else
    begin
      unique case (state_r)
        RSQ_ACTIVE:
        begin
          state_nxt   = RSQ_DELAY;
          dly_cnt_nxt = '0;
        end
        RSQ_DELAY:
        begin
          if (dly_last)
          begin
            state_nxt   = RSQ_FETCH;
            fch_cnt_nxt = '0;
          end
          else
            dly_cnt_nxt = CW'(dly_cnt_r + 1'b1);
        end
        RSQ_FETCH:
          if (fch_last)
            state_nxt = RSQ_RUN;
          else
            fch_cnt_nxt = FW'(fch_cnt_r + 1'b1);
        RSQ_RUN: state_nxt = RSQ_RUN;
      endcase
    end
  end

  // Pin drive: internal cause in active phase, all of delay, and the watchdog pulse
  assign int_cause_nxt = int_src ? 1'b1 : (state_nxt == RSQ_ACTIVE) & int_cause_r & ~lk.req_sync;
  assign wdp_cnt_nxt   = wd_underflow_in ? WW'(WD_PULSE) : (wdp_cnt_r != '0) ? WW'(wdp_cnt_r - 1'b1) : '0;
  wire   drive_nxt     = ((state_nxt == RSQ_ACTIVE) & int_cause_nxt) | (state_nxt == RSQ_DELAY)
                         | (wdp_cnt_nxt != '0);
  wire   mask_nxt      = drive_nxt | (mask_r & ~lk.pin_sync);
  wire   fetch_nxt     = (state_nxt == RSQ_FETCH);
  wire   [15:0] vec_nxt = (fch_cnt_nxt == '0) ? `RSQ_VEC_LO : `RSQ_VEC_HI;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_r     <= RSQ_ACTIVE;
      dly_cnt_r   <= '0;
      fch_cnt_r   <= '0;
      wdp_cnt_r   <= '0;
      int_cause_r <= 1'b0;
      mask_r      <= 1'b0;
      oe_n_r      <= 1'b1;
      cpu_reset_r <= 1'b1;
      vec_fetch_r <= 1'b0;
      vec_addr_r  <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      dly_cnt_r   <= dly_cnt_nxt;
      fch_cnt_r   <= fch_cnt_nxt;
      wdp_cnt_r   <= wdp_cnt_nxt;
      int_cause_r <= int_cause_nxt;
      mask_r      <= mask_nxt;
      oe_n_r      <= ~drive_nxt;
      cpu_reset_r <= (state_nxt != RSQ_RUN);
      vec_fetch_r <= fetch_nxt;
      vec_addr_r  <= fetch_nxt ? vec_nxt : '0;
    end
  end

  // ***********************************************
  // Wishbone decode
  // ***********************************************
  wire       req      = wb_cyc_in & wb_stb_in;
  wire       acc      = req & ack_r;
  wire       wr_lane  = acc & wb_we_in & wb_sel_in[0];
  wire       rd_acc   = acc & ~wb_we_in;
  wire [5:0] idx      = wb_adr_in[7:2];
  wire       hit_tc   = (idx == `RSQ_IDX_TRIM_CTL);
  wire       hit_cc   = (idx == `RSQ_IDX_CLK_CTL);
  wire       hit_th   = (idx == `RSQ_IDX_TRIM_HI);
  wire       hit_fl   = (idx == `RSQ_IDX_FLAGS);
  wire       wr_tc    = wr_lane & hit_tc;
  wire       wr_cc    = wr_lane & hit_cc;
  wire       wr_th    = wr_lane & hit_th;
  wire       wr_fl    = wr_lane & hit_fl;
  wire       rd_fl    = rd_acc & hit_fl;
  wire [7:0] rd_byte  = hit_tc ? {6'h00, lat_r, pgm_r}
                      : hit_cc ? {6'h00, clkout_en_r, slow_r}
                      : hit_th ? trim_hi_r
                      : hit_fl ? {3'h0, wdf_r, 1'b0, lsf_r, 2'h0}
                      : 8'h00;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ack_r     <= 1'b0;
      rd_byte_r <= 8'h00;
    end
    else
    begin
      ack_r     <= req & ~ack_r;
      rd_byte_r <= (req & ~ack_r) ? rd_byte : 8'h00;
    end
  end

  // ***********************************************
  // Control registers
  // ***********************************************
  // A reset mid-programming abandons the cycle; stored trim data is then undefined
  wire prog_done = pgm_r & (prog_cnt_r == PW'(PROG_CYCLES - 1));
  wire pgm_nxt   = cpu_reset_r ? 1'b0 : prog_done ? 1'b0 : wr_tc ? wb_dat_in[`RSQ_PGM_BIT] : pgm_r;
  wire lat_nxt   = cpu_reset_r ? 1'b0 : prog_done ? 1'b0
                 : wr_tc ? (wb_dat_in[`RSQ_LAT_BIT] | (lat_r & pgm_r)) : lat_r;
  // Flag sets win over software clears; supply reset beats the watchdog
  wire wdf_nxt   = lvd_on ? 1'b0 : wd_underflow_in ? 1'b1
                 : (wr_fl & ~wb_dat_in[`RSQ_WDF_BIT]) ? 1'b0 : wdf_r;
  wire lsf_nxt   = lvd_on ? 1'b1 : rd_fl ? 1'b0 : lsf_r;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lat_r       <= 1'b0;
      pgm_r       <= 1'b0;
      prog_cnt_r  <= '0;
      clkout_en_r <= 1'b0;
      slow_r      <= 1'b0;
      trim_hi_r   <= `RSQ_TRIM_HI_RST;
      wdf_r       <= 1'b0;
      lsf_r       <= 1'b0;
    end
    else
    begin
      lat_r       <= lat_nxt;
      pgm_r       <= pgm_nxt;
      prog_cnt_r  <= pgm_r ? PW'(prog_cnt_r + 1'b1) : '0;
      clkout_en_r <= cpu_reset_r ? 1'b0 : wr_cc ? wb_dat_in[`RSQ_CLKOUT_BIT] : clkout_en_r;
      slow_r      <= cpu_reset_r ? 1'b0 : wr_cc ? wb_dat_in[`RSQ_SLOW_BIT] : slow_r;
      trim_hi_r   <= cpu_reset_r ? `RSQ_TRIM_HI_RST : wr_th ? wb_dat_in[7:0] : trim_hi_r;
      wdf_r       <= wdf_nxt;
      lsf_r       <= lsf_nxt;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign wb_dat_out       = {24'h000000, rd_byte_r};
  assign wb_ack_out       = ack_r;
  assign rst_pin_out      = 1'b0;
  assign rst_pin_oe_n_out = oe_n_r;
  assign cpu_reset_out    = cpu_reset_r;
  assign vec_fetch_out    = vec_fetch_r;
  assign vec_addr_out     = vec_addr_r;
  assign cpu_clk_en_out   = lk.cpu_tick;
  assign clk_out_out      = lk.clk_out;
  assign clk_out_en_out   = clkout_en_r;
  assign trim_high_out    = trim_hi_r;
  assign trim_latch_out   = lat_r;
  assign trim_prog_out    = pgm_r;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  logic [CW:0] dly_len_r;
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      dly_len_r <= '0;
    else
      dly_len_r <= (state_r == RSQ_DELAY) ? (CW + 1)'(dly_len_r + 1'b1) : '0;
  end

  sequence fetch_lo_s;
    vec_fetch_r && vec_addr_r == `RSQ_VEC_LO;
  endsequence
  sequence fetch_hi_s;
    vec_fetch_r && vec_addr_r == `RSQ_VEC_HI;
  endsequence

  fetch_two_a: assert property ($rose(vec_fetch_r) && !src_any |-> fetch_lo_s ##1 fetch_hi_s ##1 !vec_fetch_r)
    else $error("vector fetch is not two cycles");
  fetch_after_a: assert property ($rose(vec_fetch_r) |-> $past(state_r) == RSQ_DELAY)
    else $error("vector fetch did not follow the delay phase");
  delay_len_a: assert property (state_r == RSQ_DELAY && state_nxt == RSQ_FETCH |-> dly_len_r + 1'b1 == dly_lim)
    else $error("delay phase has the wrong length");
  pin_delay_a: assert property (state_r == RSQ_DELAY |-> !rst_pin_oe_n_out)
    else $error("pin released during the delay phase");
  lvd_hold_a: assert property (lvd_on |=> cpu_reset_out && !rst_pin_oe_n_out && state_r == RSQ_ACTIVE)
    else $error("low supply does not hold reset");
  lvd_off_a: assert property (state_r == RSQ_RUN && !lk.req_sync && !supply_det_en_in
                              && !wd_underflow_in && !illegal_op_in |=> state_r == RSQ_RUN)
    else $error("disabled supply detector caused a reset");
  wd_pulse_a: assert property (wd_underflow_in |=> (!rst_pin_oe_n_out)[*8])
    else $error("watchdog pin pulse too short");
  wd_flag_clr_a: assert property (lvd_on |=> !wdf_r && lsf_r)
    else $error("supply reset did not take priority over the watchdog flag");
  restart_cnt_a: assert property (src_any |=> state_r == RSQ_ACTIVE && dly_cnt_r == '0)
    else $error("delay counter not restarted");
  ctl_zero_a: assert property (ack_r && hit_tc && !wb_we_in |-> wb_dat_out[31:2] == '0)
    else $error("trim control upper bits not zero");
  prog_end_a: assert property (prog_done && !cpu_reset_r |=> !trim_prog_out && !trim_latch_out)
    else $error("programming end did not clear both bits");
  lat_keep_a: assert property (wr_tc && pgm_r && !prog_done && !cpu_reset_r |=> trim_latch_out == $past(lat_r)
                               || $past(wb_dat_in[`RSQ_LAT_BIT]))
    else $error("latch bit cleared while programming");

endmodule : rsq_reset_seq

// *** rsq_board_model.sv ***
// Board reset circuitry on the open-drain reset pin.
// Assumes a pull-up on the pin; the device pulls low while its enable is low.
`timescale 1ns/1ps
module rsq_board_model (
  // Bench control
  input  wire logic pwr_good_in,
  input  wire logic hold_low_in,
  // Device side
  input  wire logic oe_n_in,
  output logic      pin_out
);
  // Wired AND: pull-up, device pull-down, board pull-down until power is good
  assign pin_out = oe_n_in & pwr_good_in & ~hold_low_in;
endmodule : rsq_board_model

// *** tb_top.sv ***
// Self-checking bench for the reset sequencer and its registers.
// Assumes small counts so every sequence stays short.
`timescale 1ns/1ps
`include "rsq_cfg.svh"
module tb_top;
  import rsq_pkg::*;
  localparam int DS = 4, DL = 16, WP = 10, PC = 20;
  logic        sys_clk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, q, t_hi;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic        sup_low = 0, sup_en = 0, wd = 0, ill = 0, slow = 1, pwr = 0, hold = 0, pv;
  logic        ack, pin, oe_n, pdrv, cpu_rst, vf, clk_en, clk_o, clk_oe, t_lat, t_pgm;
  logic [15:0] vaddr;
  logic [7:0]  tw [5] = '{8'hfe, 8'h00, 8'h02, 8'h03, 8'h01};
  logic [7:0]  eq [$];
  int          fail_count = 0, num_checks = 0, m_hi, n, tg, ml = 0, mp = 0;

  rsq_reset_seq #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WD_PULSE(WP), .PROG_CYCLES(PC)) i_dut (
    .sys_clk_in, .reset_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .rst_pin_in(pin),
    .rst_pin_out(pdrv), .rst_pin_oe_n_out(oe_n), .supply_low_in(sup_low), .supply_det_en_in(sup_en),
    .wd_underflow_in(wd), .illegal_op_in(ill), .slow_clk_src_in(slow), .cpu_reset_out(cpu_rst),
    .vec_fetch_out(vf), .vec_addr_out(vaddr), .cpu_clk_en_out(clk_en), .clk_out_out(clk_o),
    .clk_out_en_out(clk_oe), .trim_high_out(t_hi), .trim_latch_out(t_lat), .trim_prog_out(t_pgm));
  rsq_board_model i_brd (.pwr_good_in(pwr), .hold_low_in(hold), .oe_n_in(oe_n), .pin_out(pin));

  always #20 sys_clk_in = ~sys_clk_in;

  // *****************
  // Tasks
  // *****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  // Classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge sys_clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= s;
    wdat <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge sys_clk_in);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = rdat[7:0];
    chk(rdat[31:8], 24'h0, "upper bytes");
    chk(i < 50, 1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wait_run;
    int i;
    i = 0;
    while (cpu_rst !== 1'b0 && i < 400)
    begin
      @(posedge sys_clk_in);
      i++;
    end
    chk(i < 400, 1, "stuck in reset");
  endtask : wait_run

  // One-cycle watchdog or illegal-opcode event, then the whole sequence is measured
  task automatic pulse(input logic w, input logic s);
    int d, c, f, lo;
    d = s ? DS : DL;
    c = 0;
    f = 0;
    lo = 0;
    slow <= s;
    @(posedge sys_clk_in);
    wd  <= w;
    ill <= ~w;
    @(posedge sys_clk_in);
    wd  <= 1'b0;
    ill <= 1'b0;
    repeat (d + WP + 8)
    begin
      @(posedge sys_clk_in);
      if (f == 0 && cpu_rst === 1'b1 && vf !== 1'b1) c++;
      if (vf === 1'b1) f++;
      if (vf === 1'b1) chk(vaddr, (f == 1) ? `RSQ_VEC_LO : `RSQ_VEC_HI, "vector");
      if (oe_n === 1'b0) lo++;
    end
    chk(c, d + 1, "delay length");
    chk(f, 2, "fetch length");
    chk(lo >= d && (!w || lo >= WP), 1, "pin pulse");
    chk(cpu_rst, 0, "run");
  endtask : pulse

  task automatic results;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // *****************
  // Tests
  // *****************
  initial
  begin
    void'($urandom(45));
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    chk(cpu_rst, 1, "board holds");
    pwr <= 1'b1;
    wait_run();
    bus(0, `RSQ_IDX_TRIM_HI, 8'h00, 4'hf);
    chk(q, `RSQ_TRIM_HI_RST, "trim reset");
    m_hi = $urandom % 256;
    bus(1, `RSQ_IDX_TRIM_HI, m_hi[7:0], 4'h1);
    bus(1, `RSQ_IDX_TRIM_HI, ~m_hi[7:0], 4'he);
    bus(1, 6'h01, 8'h5a, 4'h1);
    bus(0, 6'h01, 8'h00, 4'hf);
    chk(q, 8'h00, "unmapped");
    bus(0, `RSQ_IDX_TRIM_HI, 8'h00, 4'hf);
    chk(q, m_hi[7:0], "trim high");
    chk(t_hi, m_hi[7:0], "trim out");
    for (int md = 0; md < 4; md++)
    begin
      bus(1, `RSQ_IDX_CLK_CTL, md[7:0], 4'h1);
      bus(0, `RSQ_IDX_CLK_CTL, 8'h00, 4'hf);
      chk(q[1:0], md[1:0], "clk ctl");
      n = 0;
      tg = 0;
      pv = clk_o;
      repeat (64)
      begin
        @(posedge sys_clk_in);
        if (clk_en === 1'b1) n++;
        if (clk_o !== pv) tg++;
        pv = clk_o;
      end
      chk(n, md[0] ? 2 : 64, "cpu ticks");
      chk(tg, md[1] ? n : 0, "clock out");
      chk(clk_oe, md[1], "clock out en");
    end
    foreach (tw[k])
    begin
      // Model: latch set by software, its clear ignored while programming runs
      ml = tw[k][1] | (ml & mp);
      mp = tw[k][0];
      eq.push_back({6'h00, ml[0], mp[0]});
      bus(1, `RSQ_IDX_TRIM_CTL, tw[k], 4'h1);
      bus(0, `RSQ_IDX_TRIM_CTL, 8'h00, 4'hf);
      chk(q, eq.pop_front(), "trim ctl");
    end
    chk({t_lat, t_pgm}, 2'b11, "prog outs");
    repeat (PC) @(posedge sys_clk_in);
    bus(0, `RSQ_IDX_TRIM_CTL, 8'h00, 4'hf);
    chk(q, 8'h00, "prog end");
    for (int k = 0; k < 4; k++)
    begin
      pulse(k[0], k[1]);
    end
    chk(t_hi, `RSQ_TRIM_HI_RST, "trim after reset");
    bus(1, `RSQ_IDX_TRIM_HI, 8'h80, 4'h1);
    bus(0, `RSQ_IDX_TRIM_HI, 8'h00, 4'hf);
    chk(q, 8'h80, "trim start");
    bus(0, `RSQ_IDX_FLAGS, 8'h00, 4'hf);
    chk(q & 8'h14, 8'h10, "wd flag");
    sup_low <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    chk(cpu_rst, 0, "detector off");
    sup_en <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    chk({cpu_rst, oe_n, pdrv}, 3'b100, "supply low");
    sup_low <= 1'b0;
    wait_run();
    hold <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    chk(cpu_rst, 1, "pin reset");
    hold <= 1'b0;
    wait_run();
    bus(0, `RSQ_IDX_FLAGS, 8'h00, 4'hf);
    chk(q & 8'h14, 8'h04, "supply flag");
    bus(0, `RSQ_IDX_FLAGS, 8'h00, 4'hf);
    chk(q & 8'h14, 8'h00, "read clear");
    pulse(1'b1, 1'b1);
    bus(1, `RSQ_IDX_FLAGS, 8'h10, 4'h1);
    bus(0, `RSQ_IDX_FLAGS, 8'h00, 4'hf);
    chk(q & 8'h14, 8'h10, "wd keep");
    bus(1, `RSQ_IDX_FLAGS, 8'h00, 4'h1);
    bus(0, `RSQ_IDX_FLAGS, 8'h00, 4'hf);
    chk(q & 8'h14, 8'h00, "wd clear");
    results();
  end

  initial
  begin
    #(40 * 6000);
    fail_count++;
    results();
  end
endmodule : tb_top
